//--- rtl/interrupt_priority_resolver.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module interrupt_priority_resolver (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Register port
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Interrupt flags, one per source, multi-flag groups separate
  input wire logic [17:0] SRC_FLAG,
  input wire logic [7:0] PIN_CHANGE_FLAGS,
  input wire logic [1:0] SERIAL0_FLAGS,
  input wire logic [1:0] SERIAL1_FLAGS,
  input wire logic [2:0] SPI_FLAGS,
  input wire logic [1:0] TWI_FLAGS,
  input wire logic [2:0] CAPTURE_FLAGS,
  input wire logic [17:0] SRC_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  // External interrupt pins and trigger selects
  input wire logic EXTINT0_PIN,
  input wire logic EXTINT1_PIN,
  input wire logic EXTINT0_TRIG_EDGE,
  input wire logic EXTINT1_TRIG_EDGE,
  input wire logic EXTINT0_SET,
  input wire logic EXTINT1_SET,
  input wire logic EXTINT0_SW_WR,
  input wire logic EXTINT1_SW_WR,
  input wire logic [1:0] EXTINT_SW_DATA,
  // Core handshake
  input wire logic POLL_OK,
  input wire logic RETURN_FROM_INTERRUPT,
  // Results
  output logic IRQ_TAKE,
  output logic [15:0] IRQ_VECTOR,
  output logic [4:0] IRQ_SOURCE,
  output logic [1:0] IRQ_LEVEL,
  output logic [3:0] IN_SERVICE,
  output logic EXTINT0_FLAG,
  output logic EXTINT1_FLAG,
  output logic TIMER_FLAG_CLR0,
  output logic TIMER_FLAG_CLR1,
  output logic TIMER_FLAG_CLR3,
  output logic WAKE_REQUEST
);
  ////////////////////////////////////////////////////////////////////////////////
  irq_prio_pkg::prio_regs_t regs, next_regs;
  logic [3:0] in_service, next_in_service;
  logic extint0_flag, next_extint0_flag, extint1_flag, next_extint1_flag;
  irq_prio_pkg::grant_t grant, next_grant;
  logic clr0, clr1, clr3, next_clr0, next_clr1, next_clr3;
  logic wake, next_wake;
  logic [7:0] rdata, next_rdata;
  logic [17:0] req;
  logic [1:0] lvl [18];
  logic [7:0] lo_byte [18];
  logic [7:0] hi_byte [18];
  logic [2:0] bitpos [18];

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb
  begin
    next_regs = regs;
    if (SFR_WR)
    begin
      if (SFR_ADDR == irq_prio_pkg::ADDR_PRIO_LO)
        next_regs.prio_lo = SFR_WDATA & irq_prio_pkg::PRIO_BYTE_MASK;
      if (SFR_ADDR == irq_prio_pkg::ADDR_PRIO_HI)
        next_regs.prio_hi = SFR_WDATA & irq_prio_pkg::PRIO_BYTE_MASK;
      if (SFR_ADDR == irq_prio_pkg::ADDR_EXT_LO)
        next_regs.ext_lo = SFR_WDATA;
      if (SFR_ADDR == irq_prio_pkg::ADDR_EXT_HI)
        next_regs.ext_hi = SFR_WDATA;
      if (SFR_ADDR == irq_prio_pkg::ADDR_EXT2_LO)
        next_regs.ext2_lo = SFR_WDATA & irq_prio_pkg::EXT2_BYTE_MASK;
      if (SFR_ADDR == irq_prio_pkg::ADDR_EXT2_HI)
        next_regs.ext2_hi = SFR_WDATA & irq_prio_pkg::EXT2_BYTE_MASK;
    end
    unique case (SFR_ADDR)
      irq_prio_pkg::ADDR_PRIO_LO: next_rdata = regs.prio_lo;
      irq_prio_pkg::ADDR_PRIO_HI: next_rdata = regs.prio_hi;
      irq_prio_pkg::ADDR_EXT_LO: next_rdata = regs.ext_lo;
      irq_prio_pkg::ADDR_EXT_HI: next_rdata = regs.ext_hi;
      irq_prio_pkg::ADDR_EXT2_LO: next_rdata = regs.ext2_lo;
      irq_prio_pkg::ADDR_EXT2_HI: next_rdata = regs.ext2_hi;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      regs <= '{default: irq_prio_pkg::PRIO_RESET};
      rdata <= 8'h00;
    end
    else
    begin
      regs <= next_regs;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-source level lookup: which byte pair and which bit
  always_comb
  begin
    for (int i = 0; i < 18; i++)
    begin
      lo_byte[i] = regs.ext_lo;
      hi_byte[i] = regs.ext_hi;
      bitpos[i] = 3'h0;
    end
    lo_byte[irq_prio_pkg::S_EXT0] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_TMR0] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_EXT1] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_TMR1] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_SER0] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_BOD] = regs.prio_lo;
    lo_byte[irq_prio_pkg::S_ADC] = regs.prio_lo;
    hi_byte[irq_prio_pkg::S_EXT0] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_TMR0] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_EXT1] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_TMR1] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_SER0] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_BOD] = regs.prio_hi;
    hi_byte[irq_prio_pkg::S_ADC] = regs.prio_hi;
    lo_byte[irq_prio_pkg::S_SER1] = regs.ext2_lo;
    lo_byte[irq_prio_pkg::S_TMR3] = regs.ext2_lo;
    lo_byte[irq_prio_pkg::S_WKT] = regs.ext2_lo;
    hi_byte[irq_prio_pkg::S_SER1] = regs.ext2_hi;
    hi_byte[irq_prio_pkg::S_TMR3] = regs.ext2_hi;
    hi_byte[irq_prio_pkg::S_WKT] = regs.ext2_hi;
    bitpos[irq_prio_pkg::S_EXT0] = 3'(irq_prio_pkg::B_EXT0);
    bitpos[irq_prio_pkg::S_TMR0] = 3'(irq_prio_pkg::B_TMR0);
    bitpos[irq_prio_pkg::S_EXT1] = 3'(irq_prio_pkg::B_EXT1);
    bitpos[irq_prio_pkg::S_TMR1] = 3'(irq_prio_pkg::B_TMR1);
    bitpos[irq_prio_pkg::S_SER0] = 3'(irq_prio_pkg::B_SER0);
    bitpos[irq_prio_pkg::S_BOD] = 3'(irq_prio_pkg::B_BOD);
    bitpos[irq_prio_pkg::S_ADC] = 3'(irq_prio_pkg::B_ADC);
    bitpos[irq_prio_pkg::S_TWI] = 3'(irq_prio_pkg::E_TWI);
    bitpos[irq_prio_pkg::S_PIN] = 3'(irq_prio_pkg::E_PIN);
    bitpos[irq_prio_pkg::S_CAP] = 3'(irq_prio_pkg::E_CAP);
    bitpos[irq_prio_pkg::S_PWM] = 3'(irq_prio_pkg::E_PWM);
    bitpos[irq_prio_pkg::S_WDT] = 3'(irq_prio_pkg::E_WDT);
    bitpos[irq_prio_pkg::S_FB] = 3'(irq_prio_pkg::E_FB);
    bitpos[irq_prio_pkg::S_SPI] = 3'(irq_prio_pkg::E_SPI);
    bitpos[irq_prio_pkg::S_TMR2] = 3'(irq_prio_pkg::E_TMR2);
    bitpos[irq_prio_pkg::S_SER1] = 3'(irq_prio_pkg::E2_SER1);
    bitpos[irq_prio_pkg::S_TMR3] = 3'(irq_prio_pkg::E2_TMR3);
    bitpos[irq_prio_pkg::S_WKT] = 3'(irq_prio_pkg::E2_WKT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Requests
  genvar g;
  generate
    for (g = 0; g < 18; g++)
    begin : gen_src
      logic raw;
      always_comb
      begin
        unique case (g)
          irq_prio_pkg::S_EXT0: raw = extint0_flag;
          irq_prio_pkg::S_EXT1: raw = extint1_flag;
          irq_prio_pkg::S_PIN: raw = |PIN_CHANGE_FLAGS;
          irq_prio_pkg::S_SER0: raw = |SERIAL0_FLAGS;
          irq_prio_pkg::S_SER1: raw = |SERIAL1_FLAGS;
          irq_prio_pkg::S_SPI: raw = |SPI_FLAGS;
          irq_prio_pkg::S_TWI: raw = |TWI_FLAGS;
          irq_prio_pkg::S_CAP: raw = |CAPTURE_FLAGS;
          default: raw = SRC_FLAG[g];
        endcase
      end
      assign lvl[g] = {hi_byte[g][bitpos[g]], lo_byte[g][bitpos[g]]};
      // Global gate; flags stay set at source
      assign req[g] = raw & SRC_ENABLE[g] & GLOBAL_IRQ_ENABLE;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Resolution and nesting
  always_comb
  begin
    logic found;
    logic [1:0] best_lvl;
    logic [4:0] best_src;
    logic [3:0] floor_mask;
    found = 1'b0;
    best_lvl = 2'h0;
    best_src = 5'h00;
    floor_mask = 4'h0;
    next_in_service = in_service;
    if (RETURN_FROM_INTERRUPT)
    begin
      for (int l = 0; l < 4; l++)
        if (in_service[l] && ((in_service >> (l + 1)) == 4'h0))
          next_in_service[l] = 1'b0;
    end
    for (int i = 17; i >= 0; i--)
      if (req[i] && (!found || lvl[i] >= best_lvl))
      begin
        found = 1'b1;
        best_lvl = lvl[i];
        best_src = 5'(i);
      end
    // Strictly above every level in service
    for (int l = 0; l < 4; l++)
      if (32'(best_lvl) <= l)
        floor_mask[l] = 1'b1;
    next_grant = '0;
    if (found && POLL_OK && !RETURN_FROM_INTERRUPT && ((in_service & floor_mask) == 4'h0))
    begin
      next_grant.valid = 1'b1;
      next_grant.src = best_src;
      next_grant.vector = irq_prio_pkg::VEC_TABLE[best_src];
      next_grant.level = best_lvl;
      next_in_service[best_lvl] = 1'b1;
    end
    next_wake = |(req & irq_prio_pkg::WAKE_CAPABLE);
    // Timer 0, 1, 3 cleared on entry
    next_clr0 = next_grant.valid && best_src == 5'(irq_prio_pkg::S_TMR0);
    next_clr1 = next_grant.valid && best_src == 5'(irq_prio_pkg::S_TMR1);
    next_clr3 = next_grant.valid && best_src == 5'(irq_prio_pkg::S_TMR3);
    // External flags: set wins over clear in edge mode; in level mode the flag follows the inverted pin
    next_extint0_flag = extint0_flag;
    next_extint1_flag = extint1_flag;
    if (EXTINT0_TRIG_EDGE)
    begin
      if (EXTINT0_SW_WR)
        next_extint0_flag = EXTINT_SW_DATA[0];
      if (next_grant.valid && best_src == 5'(irq_prio_pkg::S_EXT0))
        next_extint0_flag = 1'b0;
      if (EXTINT0_SET)
        next_extint0_flag = 1'b1;
    end
    else
      next_extint0_flag = ~EXTINT0_PIN;
    if (EXTINT1_TRIG_EDGE)
    begin
      if (EXTINT1_SW_WR)
        next_extint1_flag = EXTINT_SW_DATA[1];
      if (next_grant.valid && best_src == 5'(irq_prio_pkg::S_EXT1))
        next_extint1_flag = 1'b0;
      if (EXTINT1_SET)
        next_extint1_flag = 1'b1;
    end
    else
      next_extint1_flag = ~EXTINT1_PIN;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      in_service <= 4'h0;
      grant <= '0;
      extint0_flag <= 1'b0;
      extint1_flag <= 1'b0;
      clr0 <= 1'b0;
      clr1 <= 1'b0;
      clr3 <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      in_service <= next_in_service;
      grant <= next_grant;
      extint0_flag <= next_extint0_flag;
      extint1_flag <= next_extint1_flag;
      clr0 <= next_clr0;
      clr1 <= next_clr1;
      clr3 <= next_clr3;
      wake <= next_wake;
    end
  end

  assign SFR_RDATA = rdata;
  assign IRQ_TAKE = grant.valid;
  assign IRQ_VECTOR = grant.vector;
  assign IRQ_SOURCE = grant.src;
  assign IRQ_LEVEL = grant.level;
  assign IN_SERVICE = in_service;
  assign EXTINT0_FLAG = extint0_flag;
  assign EXTINT1_FLAG = extint1_flag;
  assign TIMER_FLAG_CLR0 = clr0;
  assign TIMER_FLAG_CLR1 = clr1;
  assign TIMER_FLAG_CLR3 = clr3;
  assign WAKE_REQUEST = wake;
endmodule
`default_nettype wire

//--- rtl/irq_prio_pkg.sv
`default_nettype none
package irq_prio_pkg;
  localparam int NUM_SRC = 18;
  localparam int NUM_LVL = 4;
  // Special-function register addresses
  localparam logic [7:0] ADDR_PRIO_HI = 8'hb7;
  localparam logic [7:0] ADDR_PRIO_LO = 8'hb8;
  localparam logic [7:0] ADDR_EXT_LO = 8'hef;
  localparam logic [7:0] ADDR_EXT_HI = 8'hf7;
  localparam logic [7:0] ADDR_EXT2_LO = 8'hfe;
  localparam logic [7:0] ADDR_EXT2_HI = 8'hff;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] PRIO_BYTE_MASK = 8'h7f;
  localparam logic [7:0] EXT2_BYTE_MASK = 8'h07;
  // Source index = natural rank minus one
  localparam int S_EXT0 = 0;
  localparam int S_BOD = 1;
  localparam int S_WDT = 2;
  localparam int S_TMR0 = 3;
  localparam int S_TWI = 4;
  localparam int S_ADC = 5;
  localparam int S_EXT1 = 6;
  localparam int S_PIN = 7;
  localparam int S_TMR1 = 8;
  localparam int S_SER0 = 9;
  localparam int S_FB = 10;
  localparam int S_SPI = 11;
  localparam int S_TMR2 = 12;
  localparam int S_CAP = 13;
  localparam int S_PWM = 14;
  localparam int S_SER1 = 15;
  localparam int S_TMR3 = 16;
  localparam int S_WKT = 17;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h0043, 16'h0053, 16'h000b, 16'h0033, 16'h005b,
    16'h0013, 16'h003b, 16'h001b, 16'h0023, 16'h0073, 16'h004b,
    16'h002b, 16'h0063, 16'h006b, 16'h007b, 16'h0083, 16'h008b};
  localparam logic [NUM_SRC-1:0] WAKE_CAPABLE = 18'h200c7;
  // Field positions in the priority bytes
  localparam int B_EXT0 = 0;
  localparam int B_TMR0 = 1;
  localparam int B_EXT1 = 2;
  localparam int B_TMR1 = 3;
  localparam int B_SER0 = 4;
  localparam int B_BOD = 5;
  localparam int B_ADC = 6;
  localparam int E_TWI = 0;
  localparam int E_PIN = 1;
  localparam int E_CAP = 2;
  localparam int E_PWM = 3;
  localparam int E_WDT = 4;
  localparam int E_FB = 5;
  localparam int E_SPI = 6;
  localparam int E_TMR2 = 7;
  localparam int E2_SER1 = 0;
  localparam int E2_TMR3 = 1;
  localparam int E2_WKT = 2;
  typedef struct packed {
    logic [7:0] prio_lo;
    logic [7:0] prio_hi;
    logic [7:0] ext_lo;
    logic [7:0] ext_hi;
    logic [7:0] ext2_lo;
    logic [7:0] ext2_hi;
  } prio_regs_t;
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic [15:0] vector;
    logic [1:0] level;
  } grant_t;
endpackage
`default_nettype wire

//--- dv/irq_prio_props.sv
`default_nettype none
module irq_prio_props (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Inputs watched
  input wire logic [17:0] SRC_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic EXTINT0_PIN,
  input wire logic EXTINT0_TRIG_EDGE,
  input wire logic EXTINT0_SET,
  input wire logic POLL_OK,
  input wire logic RETURN_FROM_INTERRUPT,
  // Outputs watched
  input wire logic IRQ_TAKE,
  input wire logic [15:0] IRQ_VECTOR,
  input wire logic [4:0] IRQ_SOURCE,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic [3:0] IN_SERVICE,
  input wire logic EXTINT0_FLAG,
  input wire logic TIMER_FLAG_CLR0,
  input wire logic TIMER_FLAG_CLR1,
  input wire logic TIMER_FLAG_CLR3,
  input wire logic WAKE_REQUEST
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic [3:0] popped;
  // Only the innermost handler retires
  assign popped = IN_SERVICE & ~(IN_SERVICE[3] ? 4'h8 : IN_SERVICE[2] ? 4'h4 : IN_SERVICE[1] ? 4'h2 : 4'h1);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    IRQ_TAKE && $past(RSTN);
  endsequence
  sequence s_retire;
    RETURN_FROM_INTERRUPT && IN_SERVICE != 4'h0;
  endsequence
  property p_idle_zero;
    !IRQ_TAKE |-> {IRQ_VECTOR, IRQ_SOURCE, IRQ_LEVEL} == 23'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("grant fields set while idle");
  property p_vector;
    s_take |-> IRQ_SOURCE < 5'h12 && IRQ_VECTOR == irq_prio_pkg::VEC_TABLE[IRQ_SOURCE];
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");
  property p_call_cond;
    s_take |-> $past(POLL_OK) && $past(GLOBAL_IRQ_ENABLE) && !$past(RETURN_FROM_INTERRUPT);
  endproperty
  a_call_cond: assert property (p_call_cond) else $error("call without poll or enable");
  property p_strict;
    s_take |-> ($past(IN_SERVICE) >> IRQ_LEVEL) == 4'h0 && IN_SERVICE[IRQ_LEVEL];
  endproperty
  a_strict: assert property (p_strict) else $error("call not above active levels");
  property p_retire;
    s_retire |=> IN_SERVICE == $past(popped) && !IRQ_TAKE;
  endproperty
  a_retire: assert property (p_retire) else $error("return did not pop innermost");
  property p_hold;
    !RETURN_FROM_INTERRUPT |=> (IN_SERVICE & $past(IN_SERVICE)) == $past(IN_SERVICE);
  endproperty
  a_hold: assert property (p_hold) else $error("service bit dropped without return");
  property p_timer_clr;
    {TIMER_FLAG_CLR0, TIMER_FLAG_CLR1, TIMER_FLAG_CLR3}
      == ({3{IRQ_TAKE}} & {IRQ_SOURCE == 5'h03, IRQ_SOURCE == 5'h08, IRQ_SOURCE == 5'h10});
  endproperty
  a_timer_clr: assert property (p_timer_clr) else $error("timer clear pulse wrong");
  property p_edge_clr;
    s_take ##0 (IRQ_SOURCE == 5'h00 && $past(EXTINT0_TRIG_EDGE) && !$past(EXTINT0_SET)) |-> !EXTINT0_FLAG;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge flag kept on entry");
  property p_level_flag;
    !EXTINT0_TRIG_EDGE && $past(!EXTINT0_TRIG_EDGE) && $past(RSTN) |-> EXTINT0_FLAG == !$past(EXTINT0_PIN);
  endproperty
  a_level_flag: assert property (p_level_flag) else $error("level flag not inverse of pin");
  property p_wake;
    WAKE_REQUEST && $past(RSTN) |-> $past(GLOBAL_IRQ_ENABLE && |(SRC_ENABLE & irq_prio_pkg::WAKE_CAPABLE));
  endproperty
  a_wake: assert property (p_wake) else $error("wake from a source that may not wake");
endmodule
bind interrupt_priority_resolver irq_prio_props u_props (.CORE_CLK, .RSTN, .SRC_ENABLE, .GLOBAL_IRQ_ENABLE,
  .EXTINT0_PIN, .EXTINT0_TRIG_EDGE, .EXTINT0_SET, .POLL_OK, .RETURN_FROM_INTERRUPT, .IRQ_TAKE, .IRQ_VECTOR,
  .IRQ_SOURCE, .IRQ_LEVEL, .IN_SERVICE, .EXTINT0_FLAG, .TIMER_FLAG_CLR0, .TIMER_FLAG_CLR1, .TIMER_FLAG_CLR3,
  .WAKE_REQUEST);
`default_nettype wire

//--- dv/core_model.sv
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench control
  input wire logic [1:0] mode,
  input wire logic ret_req,
  // Core handshake
  output logic poll_ok,
  output logic ret
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  logic seen = 1'b0;
  initial
  begin
    poll_ok = 1'b0;
    ret = 1'b0;
  end
  // Slow mode polls one cycle in four, like long instructions
  always @(posedge clk)
  begin
    seen = ret_req;
    #10;
    phase = phase + 1;
    ret = rstn && seen;
    poll_ok = rstn && !ret && (mode == 2'h1 || (mode == 2'h2 && phase % 4 == 0));
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, ret_req = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pinf = 8'h00, d, rdata;
  logic [17:0] flag = 18'h0, en = 18'h3ffff;
  logic [1:0] s0f = 2'h0, s1f = 2'h0, twif = 2'h0, mode = 2'h1, lvl;
  logic [2:0] spif = 3'h0, capf = 3'h0;
  logic gie = 1'b1, p0 = 1'b1, p1 = 1'b1, t0 = 1'b0, set0 = 1'b0;
  logic t1 = 1'b0, set1 = 1'b0, swwr = 1'b0;
  logic [1:0] swd = 2'h0;
  logic take, f0, f1, c0, c1, c3, wake, poll, ret;
  logic [15:0] vec;
  logic [4:0] src;
  logic [3:0] insvc;
  int fail_count = 0, checked = 0, cycles = 0, seed = 32'h23e7;
  irq_prio_pkg::grant_t exp_q[$];
  logic [7:0] ra [7] = '{8'hb7, 8'hb8, 8'hef, 8'hf7, 8'hfe, 8'hff, 8'h42};
  logic [7:0] rm [7] = '{8'h7f, 8'h7f, 8'hff, 8'hff, 8'h07, 8'h07, 8'h00};
  logic [15:0] vt [18] = '{16'h0003, 16'h0043, 16'h0053, 16'h000b, 16'h0033, 16'h005b, 16'h0013, 16'h003b,
    16'h001b, 16'h0023, 16'h0073, 16'h004b, 16'h002b, 16'h0063, 16'h006b, 16'h007b, 16'h0083, 16'h008b};
  logic [17:0] wk = 18'h200c7;
  interrupt_priority_resolver uut (.CORE_CLK(clk), .RSTN(rstn), .SFR_WR(wr), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SRC_FLAG(flag), .PIN_CHANGE_FLAGS(pinf), .SERIAL0_FLAGS(s0f),
    .SERIAL1_FLAGS(s1f), .SPI_FLAGS(spif), .TWI_FLAGS(twif), .CAPTURE_FLAGS(capf), .SRC_ENABLE(en),
    .GLOBAL_IRQ_ENABLE(gie), .EXTINT0_PIN(p0), .EXTINT1_PIN(p1), .EXTINT0_TRIG_EDGE(t0),
    .EXTINT1_TRIG_EDGE(t1), .EXTINT0_SET(set0), .EXTINT1_SET(set1), .EXTINT0_SW_WR(swwr),
    .EXTINT1_SW_WR(swwr), .EXTINT_SW_DATA(swd), .POLL_OK(poll), .RETURN_FROM_INTERRUPT(ret),
    .IRQ_TAKE(take), .IRQ_VECTOR(vec), .IRQ_SOURCE(src), .IRQ_LEVEL(lvl), .IN_SERVICE(insvc),
    .EXTINT0_FLAG(f0), .EXTINT1_FLAG(f1), .TIMER_FLAG_CLR0(c0), .TIMER_FLAG_CLR1(c1), .TIMER_FLAG_CLR3(c3),
    .WAKE_REQUEST(wake));
  core_model partner (.clk(clk), .rstn(rstn), .mode(mode), .ret_req(ret_req), .poll_ok(poll), .ret(ret));
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // Every call must match the oldest note
  always @(posedge clk)
  begin
    #2;
    if (take === 1'b1)
      check("grant", {take, src, vec, lvl}, exp_q.size() ? exp_q.pop_front() : 24'h0);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) #10;
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge clk) #10;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #10;
    addr = a;
    @(posedge clk) #2;
    check("rdata", rdata, e);
  endtask
  task automatic req(input int i, input logic on);
    logic [7:0] r;
    r = 8'($random(seed));
    case (i)
      0: p0 = !on;
      4: twif = on ? 2'h1 << r[0] : 2'h0;
      6: p1 = !on;
      7: pinf = on ? 8'h01 << r[2:0] : 8'h00;
      9: s0f = on ? 2'h1 << r[0] : 2'h0;
      11: spif = on ? 3'h1 << (r[1:0] % 2'h3) : 3'h0;
      13: capf = on ? 3'h1 << (r[1:0] % 2'h3) : 3'h0;
      15: s1f = on ? 2'h1 << r[0] : 2'h0;
      default: flag[i] = on;
    endcase
  endtask
  function automatic irq_prio_pkg::grant_t g(input int s, input logic [1:0] l);
    return '{1'b1, 5'(s), vt[s], l};
  endfunction
  task automatic await_take(input irq_prio_pkg::grant_t e);
    exp_q.push_back(e);
    for (int k = 0; k < 20 && exp_q.size() != 0; k++)
      @(posedge clk) #5;
    check("take seen", exp_q.size(), 0);
    #5;
  endtask
  task automatic do_ret(input logic [3:0] e);
    ret_req = 1'b1;
    @(posedge clk) #10;
    ret_req = 1'b0;
    @(posedge clk) #10;
    check("in service", insvc, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    #10;
    rstn = 1'b1;
    for (int i = 0; i < 7; i++)
      rd_reg(ra[i], 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($random(seed));
      wr_reg(ra[i], d);
      rd_reg(ra[i], d & rm[i]);
      wr_reg(ra[i], 8'h00);
    end
    for (int i = 0; i < 18; i++)
    begin
      mode = i[0] ? 2'h2 : 2'h1;
      req(i, 1'b1);
      await_take(g(i, 2'h0));
      check("wake", wake, wk[i]);
      check("timer clear", {c0, c1, c3}, {i == 3, i == 8, i == 16});
      if (i == 0 || i == 6)
        check("level flag", i ? f1 : f0, 1'b1);
      req(i, 1'b0);
      do_ret(4'h0);
    end
    wr_reg(8'hb7, 8'h19);
    wr_reg(8'hb8, 8'h01);
    mode = 2'h0;
    req(3, 1'b1);
    req(9, 1'b1);
    req(8, 1'b1);
    @(posedge clk) #10;
    mode = 2'h1;
    await_take(g(8, 2'h2));
    req(8, 1'b0);
    req(0, 1'b1);
    await_take(g(0, 2'h3));
    req(0, 1'b0);
    do_ret(4'h4);
    do_ret(4'h0);
    await_take(g(9, 2'h2));
    req(9, 1'b0);
    do_ret(4'h0);
    await_take(g(3, 2'h0));
    req(3, 1'b0);
    do_ret(4'h0);
    wr_reg(8'hef, 8'h80);
    gie = 1'b0;
    req(12, 1'b1);
    repeat (6) @(posedge clk);
    #10;
    gie = 1'b1;
    await_take(g(12, 2'h1));
    req(12, 1'b0);
    do_ret(4'h0);
    t0 = 1'b1;
    @(posedge clk) #10;
    set0 = 1'b1;
    @(posedge clk) #10;
    set0 = 1'b0;
    await_take(g(0, 2'h3));
    check("edge flag", f0, 1'b0);
    do_ret(4'h0);
    // software write ignored in level mode
    t0 = 1'b0;
    swwr = 1'b1;
    swd = 2'h3;
    @(posedge clk) #10;
    swwr = 1'b0;
    @(posedge clk) #10;
    check("soft write", {f0, f1}, 2'h0);
    t1 = 1'b1;
    set1 = 1'b1;
    @(posedge clk) #10;
    set1 = 1'b0;
    await_take(g(6, 2'h0));
    check("edge flag 1", f1, 1'b0);
    do_ret(4'h0);
    finish_test();
  end
endmodule
`default_nettype wire
